// File: logic/rlc_pkg.sv
// Contract
// (RULE1) Separate none/add/subtract option per repeated half
// (RULE2) None option: normal indexing, auto-count stays active
// (RULE3) No index named: full address field is address
// (RULE4) Add/subtract: index is address, then updated
// (RULE5) Add/subtract without short flag: address forced zero
// (RULE6) That case updates index with full field
// (RULE7) Loop done: fetch next word, continue sequencing
// (RULE8) Zero count skips the repeated instructions
// (RULE9) Counter steps through adder into memory address
// (RULE10) Left jump copies memory address to jump address
// (RULE11) Remaining right runs = jump addr - 4096 + count
// (RULE12) Right jump copies program address to jump address
// (RULE13) Index register instruction ignores add/subtract option
// (RULE14) Counter-to-index transfer treated as ordinary indexable
// (RULE15) Left repeat repeats right half; right repeats pair
// (RULE16) Count field accepts zero up to 4095
// (RULE17) Add/subtract suppresses index auto-count increment
// (RULE18) Repeat instruction itself is never index modified
// (RULE19) Count once per pass; stop at end or jump
// (RULE20) Index update only after the instruction completes
package rlc_pkg;

    localparam int ADDR_W = 15;
    localparam int V_W    = 12;
    localparam int CNT_W  = 12;
    localparam int MAR_W  = 13;
    localparam int SEL_W  = 5;

    // Counter base: the loop counts down from here
    localparam logic [MAR_W-1:0] CNT_BASE = 13'h1000;

    // --------------------------------------------------------------
    // Register map
    // --------------------------------------------------------------
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_STAT = 12'h004;
    localparam logic [11:0] REG_MAR  = 12'h008;
    localparam logic [11:0] REG_JAR  = 12'h00c;
    localparam logic [11:0] REG_CNT  = 12'h010;
    localparam int          CTRL_EN  = 0;
    localparam logic        CTRL_RST = 1'b1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        OPT_NONE = 2'h0,
        OPT_ADD  = 2'h1,
        OPT_SUB  = 2'h2
    } rlc_opt_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RUN  = 3'b010,
        ST_STEP = 3'b100
    } rlc_st_t;

endpackage

// File: logic/rlc_repeat_ctrl.sv
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/1ps
module rlc_repeat_ctrl
    import rlc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [11:0]       awaddr,
    input  wire logic              wvalid,
    output logic                   wready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    output logic                   bvalid,
    input  wire logic              bready,
    output logic [1:0]             bresp,
    input  wire logic              arvalid,
    output logic                   arready,
    input  wire logic [11:0]       araddr,
    output logic                   rvalid,
    input  wire logic              rready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    input  wire logic              rep_start,
    input  wire logic              rep_half,
    input  wire logic [CNT_W-1:0]  rep_count,
    input  wire logic [1:0]        rep_opt_l,
    input  wire logic [1:0]        rep_opt_r,
    input  wire logic              exec_req,
    input  wire logic              ins_half,
    input  wire logic              ins_s,
    input  wire logic [SEL_W-1:0]  ins_sel,
    input  wire logic [V_W-1:0]    ins_v,
    input  wire logic [ADDR_W-1:0] ins_full,
    input  wire logic              ins_is_ixr,
    input  wire logic              ins_is_xfer,
    input  wire logic [ADDR_W-1:0] idx_val,
    input  wire logic              exec_done,
    input  wire logic              jump_taken,
    input  wire logic [ADDR_W-1:0] pc_in,
    output logic                   loop_active,
    output logic                   pair_mode,
    output logic [ADDR_W-1:0]      ea,
    output logic                   ea_valid,
    output logic                   auto_count,
    output logic                   idx_wr_en,
    output logic [SEL_W-1:0]       idx_wr_sel,
    output logic [ADDR_W-1:0]      idx_wr_data,
    output logic [MAR_W-1:0]       jump_address_reg,
    output logic [MAR_W-1:0]       memory_address_reg,
    output logic                   load_next
);

    typedef struct packed {
        rlc_st_t           st;
        logic              en;
        logic [MAR_W-1:0]  cnt;
        logic [MAR_W-1:0]  mar;
        logic [MAR_W-1:0]  lim;
        logic [MAR_W-1:0]  jar;
        logic              act;
        logic [CNT_W-1:0]  n;
        rlc_opt_t          opt_l;
        rlc_opt_t          opt_r;
        logic              two;
        logic [ADDR_W-1:0] ea;
        logic              ea_v;
        logic              ac;
        logic              upd;
        logic              sub;
        logic [ADDR_W-1:0] idx;
        logic [ADDR_W-1:0] amt;
        logic              wr_en;
        logic [SEL_W-1:0]  wr_sel;
        logic [ADDR_W-1:0] wr_data;
        logic              load_next;
        logic              aw_have;
        logic              w_have;
        logic [11:0]       awaddr;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              awready;
        logic              wready;
        logic              bvalid;
        logic [1:0]        bresp;
        logic              arready;
        logic              rvalid;
        logic [31:0]       rdata;
        logic [1:0]        rresp;
    } rlc_state_t;

    localparam rlc_state_t S_RST = '{st: ST_IDLE, en: CTRL_RST,
                                     opt_l: OPT_NONE, opt_r: OPT_NONE, default: '0};

    rlc_state_t        s_q;
    rlc_state_t        s_d;
    logic              ix_eff;
    rlc_opt_t          opt_cur;
    logic              rmode;
    logic              start_ok;
    logic [ADDR_W-1:0] ins_amt;

    // --------------------------------------------------------------
    // Decode of the instruction under repeat
    // --------------------------------------------------------------
    // Transfer-counter commands look like index ops but index normally
    assign ix_eff   = ins_is_ixr && !ins_is_xfer;                 // RULE13 RULE14
    assign opt_cur  = ins_half ? s_q.opt_r : s_q.opt_l;           // RULE1
    assign rmode    = (opt_cur != OPT_NONE) && !ix_eff;            // RULE13
    // Without the short flag the whole field is the update step
    assign ins_amt  = ins_s ? {{(ADDR_W-V_W){1'b0}}, ins_v} : ins_full; // RULE4 RULE6
    assign start_ok = (s_q.st == ST_IDLE) && s_q.en && rep_start;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == REG_CTRL) || (a == REG_STAT) || (a == REG_MAR) ||
                 (a == REG_JAR) || (a == REG_CNT);
    endfunction

    always_comb
    begin
        s_d           = s_q;
        s_d.ea_v      = 1'b0;
        s_d.wr_en     = 1'b0;
        s_d.load_next = 1'b0;

        // ----------------------------------------------------------
        // Register bus: write
        // ----------------------------------------------------------
        if (s_q.awready && awvalid)
        begin
            s_d.aw_have = 1'b1;
            s_d.awaddr  = awaddr;
        end
        if (s_q.wready && wvalid)
        begin
            s_d.w_have = 1'b1;
            s_d.wdata  = wdata;
            s_d.wstrb  = wstrb;
        end
        if (s_q.bvalid && bready)
            s_d.bvalid = 1'b0;
        if (s_d.aw_have && s_d.w_have && !s_d.bvalid)
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = mapped(s_d.awaddr) ? RESP_OKAY : RESP_DECERR;
            if (s_d.awaddr == REG_CTRL && s_d.wstrb[0])
                s_d.en = s_d.wdata[CTRL_EN];
        end
        // Hold off new halves until the response has gone
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;

        // ----------------------------------------------------------
        // Register bus: read
        // ----------------------------------------------------------
        if (s_q.rvalid && rready)
            s_d.rvalid = 1'b0;
        if (s_q.arready && arvalid)
        begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            unique case (araddr)
                REG_CTRL: s_d.rdata = {31'h0, s_q.en};
                REG_STAT: s_d.rdata = {27'h0, s_q.two, s_q.st, s_q.st != ST_IDLE};
                REG_MAR:  s_d.rdata = {19'h0, s_q.mar};
                REG_JAR:  s_d.rdata = {19'h0, s_q.jar};
                REG_CNT:  s_d.rdata = {20'h0, s_q.n};
                default:
                begin
                    s_d.rdata = 32'h0;
                    s_d.rresp = RESP_DECERR;
                end
            endcase
        end
        s_d.arready = !s_d.rvalid;

        // ----------------------------------------------------------
        // Repeat sequencing
        // ----------------------------------------------------------
        unique case (s_q.st)
            ST_IDLE:
            begin
                if (start_ok)
                begin
                    // Count is taken raw: the repeat op has no indexing
                    s_d.n     = rep_count;                          // RULE16 RULE18
                    s_d.cnt   = CNT_BASE;
                    s_d.mar   = CNT_BASE;
                    s_d.lim   = CNT_BASE - {1'b0, rep_count};       // RULE11
                    s_d.two   = rep_half;                           // RULE15
                    s_d.opt_l = rlc_opt_t'(rep_opt_l);              // RULE1
                    s_d.opt_r = rlc_opt_t'(rep_opt_r);              // RULE1
                    s_d.upd   = 1'b0;
                    if (rep_count == 12'h000)
                        s_d.load_next = 1'b1;                       // RULE8
                    else
                        s_d.st = ST_RUN;
                end
            end
            ST_RUN:
            begin
                if (exec_req)
                begin
                    s_d.ea_v = 1'b1;
                    if (rmode)
                    begin
                        s_d.ea     = ins_s ? idx_val : '0;          // RULE4 RULE5
                        s_d.ac     = 1'b0;                          // RULE17
                        s_d.upd    = 1'b1;
                        s_d.sub    = (opt_cur == OPT_SUB);
                        s_d.idx    = idx_val;
                        s_d.amt    = ins_amt;
                        s_d.wr_sel = ins_sel;
                    end
                    else
                    begin
                        s_d.ea  = ins_s ? idx_val + {{(ADDR_W-V_W){1'b0}}, ins_v}
                                        : ins_full;                 // RULE2 RULE3
                        s_d.ac  = ins_s;                            // RULE2
                        s_d.upd = 1'b0;
                    end
                end
                if (exec_done)
                begin
                    // Update uses the value latched before execution
                    if (s_q.upd)
                    begin
                        s_d.wr_en   = 1'b1;                         // RULE20
                        s_d.wr_data = s_q.sub ? s_q.idx - s_q.amt
                                              : s_q.idx + s_q.amt;  // RULE4
                        s_d.upd     = 1'b0;
                    end
                    if (jump_taken)
                    begin
                        s_d.jar = ins_half ? {1'b0, pc_in[MAR_W-2:0]} // RULE12
                                           : s_q.mar;                 // RULE10
                        s_d.st = ST_IDLE;                           // RULE19
                    end
                    else if (ins_half)
                    begin
                        s_d.mar = s_q.cnt - 13'h1;                  // RULE9
                        s_d.st = ST_STEP;
                    end
                end
            end
            ST_STEP:
            begin
                s_d.cnt = s_q.mar;                                  // RULE9
                if (s_q.mar == s_q.lim)
                begin
                    s_d.load_next = 1'b1;                           // RULE7 RULE19
                    s_d.st        = ST_IDLE;
                end
                else
                    s_d.st = ST_RUN;
            end
        endcase
        s_d.act = (s_d.st != ST_IDLE);
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_q <= S_RST;
        else
            s_q <= s_d;
    end

    // --------------------------------------------------------------
    // Outputs
    // --------------------------------------------------------------
    assign awready            = s_q.awready;
    assign wready             = s_q.wready;
    assign bvalid             = s_q.bvalid;
    assign bresp              = s_q.bresp;
    assign arready            = s_q.arready;
    assign rvalid             = s_q.rvalid;
    assign rdata              = s_q.rdata;
    assign rresp              = s_q.rresp;
    assign loop_active        = s_q.act;
    assign pair_mode          = s_q.two;
    assign ea                 = s_q.ea;
    assign ea_valid           = s_q.ea_v;
    assign auto_count         = s_q.ac;
    assign idx_wr_en          = s_q.wr_en;
    assign idx_wr_sel         = s_q.wr_sel;
    assign idx_wr_data        = s_q.wr_data;
    assign jump_address_reg   = s_q.jar;
    assign memory_address_reg = s_q.mar;
    assign load_next          = s_q.load_next;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic run_req;
    logic run_done;
    assign run_req  = (s_q.st == ST_RUN) && exec_req;
    assign run_done = (s_q.st == ST_RUN) && exec_done;

    property p_zero_skip;
        start_ok && rep_count == 12'h000 |=> load_next && !loop_active;
    endproperty
    a_zero_skip: assert property (p_zero_skip) else $error("zero count not skipped"); // RULE8

    property p_rm_zero;
        run_req && rmode && !ins_s |=> ea_valid && ea == 15'h0000 && !auto_count;
    endproperty
    a_rm_zero: assert property (p_rm_zero) else $error("repeat ea not zero"); // RULE5

    property p_rm_index;
        run_req && rmode && ins_s |=> ea == $past(idx_val) && !auto_count;
    endproperty
    a_rm_index: assert property (p_rm_index) else $error("repeat ea not index"); // RULE17

    property p_no_index;
        run_req && !rmode && !ins_s |=> ea == $past(ins_full) && !auto_count;
    endproperty
    a_no_index: assert property (p_no_index) else $error("full field not used"); // RULE3

    property p_normal;
        run_req && !rmode && ins_s |=> auto_count && ea == $past(idx_val) + $past(ins_v);
    endproperty
    a_normal: assert property (p_normal) else $error("normal indexing wrong"); // RULE2

    property p_upd_full;
        run_req && rmode && !ins_s
            |=> s_q.upd && s_q.amt == $past(ins_full) && s_q.idx == $past(idx_val) && s_q.wr_sel == $past(ins_sel);
    endproperty
    a_upd_full: assert property (p_upd_full) else $error("full field not latched"); // RULE6

    property p_ixr;
        run_req && ix_eff |=> !s_q.upd;
    endproperty
    a_ixr: assert property (p_ixr) else $error("index op was modified"); // RULE13

    property p_ljump;
        run_done && jump_taken && !ins_half |=> jump_address_reg == $past(s_q.mar) && !loop_active;
    endproperty
    a_ljump: assert property (p_ljump) else $error("left jump address"); // RULE10

    property p_rjump;
        run_done && jump_taken && ins_half |=> jump_address_reg[11:0] == $past(pc_in[11:0]);
    endproperty
    a_rjump: assert property (p_rjump) else $error("right jump address"); // RULE12

    property p_step;
        run_done && !jump_taken && ins_half
            |=> memory_address_reg == $past(s_q.cnt) - 13'h1 ##1 s_q.cnt == $past(s_q.mar);
    endproperty
    a_step: assert property (p_step) else $error("counter step wrong"); // RULE9

    property p_end;
        s_q.st == ST_STEP && s_q.mar == s_q.lim |=> load_next && !loop_active;
    endproperty
    a_end: assert property (p_end) else $error("loop end missed"); // RULE7

    c_skip: cover property (start_ok && rep_count == 12'h000);
    c_pair: cover property (s_q.st == ST_STEP && s_q.two && s_q.mar == s_q.lim);
    c_jump: cover property (run_done && jump_taken && !ins_half);
    c_sub:  cover property (idx_wr_en && s_q.sub);

endmodule // rlc_repeat_ctrl

// File: tb/rlc_repeat_ctrl_tb.sv
`timescale 1ns/1ps
module rlc_repeat_ctrl_tb
    import rlc_pkg::*;
;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid;
    logic              rready, rep_start, rep_half, exec_req, ins_half, ins_s, ins_is_ixr, ins_is_xfer, jump_req;
    logic              exec_done, jump_taken, loop_active, pair_mode, ea_valid, auto_count, idx_wr_en, load_next;
    logic [1:0]        bresp, rresp, rep_opt_l, rep_opt_r;
    logic [3:0]        wstrb, dly;
    logic [11:0]       awaddr, araddr;
    logic [31:0]       wdata, rdata;
    logic [CNT_W-1:0]  rep_count;
    logic [SEL_W-1:0]  ins_sel, idx_wr_sel;
    logic [V_W-1:0]    ins_v;
    logic [ADDR_W-1:0] ins_full, idx_val, pc_in, ea, idx_wr_data;
    logic [MAR_W-1:0]  jump_address_reg, memory_address_reg;
    logic [ADDR_W-1:0] xr [32];
    int                fail_count, checked;

    rlc_repeat_ctrl dut_u (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready,
        .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .rep_start, .rep_half,
        .rep_count, .rep_opt_l, .rep_opt_r, .exec_req, .ins_half, .ins_s, .ins_sel, .ins_v, .ins_full,
        .ins_is_ixr, .ins_is_xfer, .idx_val, .exec_done, .jump_taken, .pc_in, .loop_active, .pair_mode, .ea,
        .ea_valid, .auto_count, .idx_wr_en, .idx_wr_sel, .idx_wr_data, .jump_address_reg, .memory_address_reg,
        .load_next
    );
    rlc_seq_model model_u (
        .aclk, .exec_req, .jump_req, .dly, .ins_sel, .idx_wr_en, .idx_wr_sel, .idx_wr_data, .exec_done,
        .jump_taken, .idx_val
    );

    always #2 aclk = ~aclk;

    // Longest test is the 4095 pass loop at about three cycles a pass
    initial
    begin
        repeat (40000) @(posedge aclk);
        fail_count++;
        finish_test();
    end

    task automatic finish_test();
        $display("Mismatches %0d of %0d comparisons", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge aclk);
        #1;
    endtask

    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic a_ok, w_ok;
        {a_ok, w_ok} = 2'b00;
        @(posedge aclk);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'b111;
        while (!(a_ok && w_ok))
        begin
            @(posedge aclk);
            if (awready === 1'b1)
                awvalid <= 1'b0;
            if (wready === 1'b1)
                wvalid <= 1'b0;
            a_ok = a_ok || awready === 1'b1;
            w_ok = w_ok || wready === 1'b1;
        end
        while (bvalid !== 1'b1)
            @(posedge aclk);
        bready <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        @(posedge aclk);
        while (arready !== 1'b1)
            @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1)
            @(posedge aclk);
        rready <= 1'b0;
        chk({rdata, rresp}, {ed, er});
    endtask

    task automatic rep(input logic h, input logic [CNT_W-1:0] n, input logic [1:0] ol, orr);
        @(posedge aclk);
        {rep_start, rep_half, rep_count, rep_opt_l, rep_opt_r} <= {1'b1, h, n, ol, orr};
        @(posedge aclk);
        rep_start <= 1'b0;
        #1;
    endtask

    // Fields stay put until done, since ins_half also picks the jump kind at completion
    task automatic exec(input logic h, s, ixr, xf, jmp, input logic [1:0] opt, input logic [SEL_W-1:0] sel,
                        input logic [V_W-1:0] v, input logic [ADDR_W-1:0] full);
        logic [1:0]        eo;
        logic [ADDR_W-1:0] xe;
        eo = (ixr && !xf) ? OPT_NONE : opt;
        xe = (eo == OPT_ADD) ? xr[sel] + (s ? ADDR_W'(v) : full) : xr[sel] - (s ? ADDR_W'(v) : full);
        @(posedge aclk);
        {exec_req, ins_half, ins_s, ins_is_ixr, ins_is_xfer, jump_req} <= {1'b1, h, s, ixr, xf, jmp};
        {ins_sel, ins_v, ins_full} <= {sel, v, full};
        @(posedge aclk);
        exec_req <= 1'b0;
        #1;
        chk(ea_valid, 1'b1);
        if (!ixr || xf)
            chk(ea, (eo == OPT_NONE) ? (s ? xr[sel] + v : full) : (s ? xr[sel] : 15'h0));
        if (s)
            chk(auto_count, eo == OPT_NONE);
        while (exec_done !== 1'b1)
            tick();
        tick();
        chk(idx_wr_en, eo != OPT_NONE);
        if (eo != OPT_NONE)
        begin
            chk({idx_wr_sel, idx_wr_data}, {sel, xe});
            xr[sel] = xe;
        end
    endtask

    initial
    begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, rep_start, rep_half, exec_req} = '0;
        {ins_half, ins_s, ins_is_ixr, ins_is_xfer, jump_req, rep_opt_l, rep_opt_r, dly} = '0;
        {awaddr, araddr, wdata, rep_count, ins_sel, ins_v, ins_full, pc_in} = '0;
        {wstrb, fail_count, checked} = {4'hf, 32'd0, 32'd0};
        for (int i = 0; i < 32; i++)
            xr[i] = ADDR_W'(i * 256);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(REG_CTRL, 32'h1, RESP_OKAY);
        axi_rd(12'h0fc, 32'h0, RESP_DECERR);
        axi_wr(12'h0fc, 32'hffff_ffff, RESP_DECERR);
        axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
        rep(1'b0, 12'h001, OPT_NONE, OPT_NONE);
        chk(loop_active, 1'b0);
        axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
        // A second start while running must be ignored
        rep(1'b0, 12'h002, OPT_NONE, OPT_ADD);
        rep(1'b1, 12'h007, OPT_NONE, OPT_NONE);
        chk(pair_mode, 1'b0);
        axi_rd(REG_STAT, 32'h5, RESP_OKAY);
        axi_rd(REG_CNT, 32'h2, RESP_OKAY);
        for (int k = 1; k <= 2; k++)
        begin
            exec(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, OPT_ADD, 5'h03, 12'h005, 15'h0);
            chk(memory_address_reg, CNT_BASE - k);
        end
        tick();
        chk(load_next, 1'b1);
        dly = 4'h3;
        rep(1'b1, 12'h003, OPT_NONE, OPT_SUB);
        chk(pair_mode, 1'b1);
        for (int k = 1; k <= 3; k++)
        begin
            exec(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, OPT_NONE, 5'h01, 12'h007, 15'h0);
            exec(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, OPT_SUB, 5'h02, 12'h000, 15'h0011);
        end
        tick();
        chk(load_next, 1'b1);
        dly = 4'h0;
        rep(1'b0, 12'h000, OPT_ADD, OPT_ADD);
        // The skip pulse stands only in the cycle right after the start
        chk(loop_active, 1'b0);
        chk(load_next, 1'b1);
        rep(1'b1, 12'h003, OPT_NONE, OPT_NONE);
        exec(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, OPT_NONE, 5'h04, 12'h0bc, 15'h2abc);
        exec(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, OPT_NONE, 5'h04, 12'h123, 15'h0123);
        exec(1'b0, 1'b1, 1'b0, 1'b0, 1'b1, OPT_NONE, 5'h04, 12'h010, 15'h0);
        chk(jump_address_reg, CNT_BASE - 1);
        chk(jump_address_reg - 4096 + 3, 32'h2);
        chk(loop_active, 1'b0);
        tick();
        chk(load_next, 1'b0);
        @(posedge aclk);
        pc_in <= 15'h5234;
        rep(1'b0, 12'h005, OPT_NONE, OPT_NONE);
        exec(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, OPT_NONE, 5'h00, 12'h000, 15'h0040);
        chk({jump_address_reg, loop_active}, {13'h0234, 1'b0});
        rep(1'b0, 12'h001, OPT_NONE, OPT_ADD);
        exec(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, OPT_ADD, 5'h05, 12'h009, 15'h0);
        tick();
        rep(1'b0, 12'h001, OPT_NONE, OPT_SUB);
        exec(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, OPT_SUB, 5'h06, 12'h004, 15'h0);
        tick();
        rep(1'b0, 12'hfff, OPT_NONE, OPT_NONE);
        for (int k = 1; k <= 4095; k++)
            exec(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, OPT_NONE, 5'h07, 12'h001, 15'h0);
        chk(memory_address_reg, 13'h0001);
        tick();
        chk(load_next, 1'b1);
        finish_test();
    end
endmodule // rlc_repeat_ctrl_tb

// File: tb/rlc_seq_model.sv
`timescale 1ns/1ps
module rlc_seq_model
    import rlc_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              exec_req,
    input  wire logic              jump_req,
    input  wire logic [3:0]        dly,
    input  wire logic [SEL_W-1:0]  ins_sel,
    input  wire logic              idx_wr_en,
    input  wire logic [SEL_W-1:0]  idx_wr_sel,
    input  wire logic [ADDR_W-1:0] idx_wr_data,
    output logic                   exec_done,
    output logic                   jump_taken,
    output logic [ADDR_W-1:0]      idx_val
);
    logic [ADDR_W-1:0] regs_q [32];
    logic [3:0]        wait_q = 4'h0;
    wire               fin    = (exec_req && dly == 4'h0) || (!exec_req && wait_q == 4'h1);

    initial
    begin
        for (int i = 0; i < 32; i++)
            regs_q[i] = ADDR_W'(i * 256);
    end

    // Content is only valid in the presenting cycle; a late sample sees inverted bits
    assign idx_val = exec_req ? regs_q[ins_sel] : ~regs_q[ins_sel];

    // Completion comes dly cycles after the request, so both prompt and slow answers occur
    always @(posedge aclk)
    begin
        exec_done  <= fin;
        jump_taken <= fin && jump_req;
        wait_q     <= exec_req ? dly : wait_q - 4'(wait_q != 4'h0);
        if (idx_wr_en)
            regs_q[idx_wr_sel] <= idx_wr_data;
    end
endmodule // rlc_seq_model
